// >>> tsc_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants and types of the touch converter serial control block
// ----------------------------------------------------------------------------
package tsc_pkg;

   // Core clock period and the slowest allowed answer to a conv_clock falling edge.
   localparam int CLK_PERIOD_NS   = 40;
   localparam int T_OUT_MAX_NS    = 200;
   localparam int OUT_MAX_CYC     = (T_OUT_MAX_NS / CLK_PERIOD_NS < 1) ? 1
                                    : T_OUT_MAX_NS / CLK_PERIOD_NS;
   // Two synchroniser stages, one edge detect flop and one output flop.
   localparam int PIN_LATENCY_CYC = 4;

   // Framing counts of the serial link.
   localparam int CMD_BITS        = 8;
   localparam int ACQ_AFTER_BITS  = 4;
   localparam int RES_HI          = 12;
   localparam int RES_LO          = 8;

   // APB register offsets (byte addresses).
   localparam logic [7:0] OFF_SAMPLE = 8'h00;
   localparam logic [7:0] OFF_RESULT = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;

   // STATUS field positions.
   localparam int ST_BUSY_BIT  = 0;
   localparam int ST_REF_BIT   = 1;
   localparam int ST_ADC_BIT   = 2;
   localparam int ST_DRIVE_BIT = 3;
   localparam int ST_IRQEN_BIT = 4;
   localparam int ST_STATE_LSB = 6;
   localparam int ST_CTRL_LSB  = 8;

   // Reset values.
   localparam logic [7:0]  CTRL_RST   = 8'h00;
   localparam logic [2:0]  SYNC_RST   = 3'h4;
   localparam logic [31:0] RDATA_RST  = 32'h0000_0000;

   // Control byte as it arrives, most significant bit first.
   typedef struct packed {
      logic       start_flag;
      logic [2:0] channel_sel;
      logic       res_8bit;
      logic       ref_select;
      logic       power_bit1;
      logic       power_bit0;
   } tsc_ctrl_t;

   // Power and driver outputs travel together.
   typedef struct packed {
      logic drive;
      logic adc_on;
      logic ref_on;
      logic irq_en;
   } tsc_power_t;

   // Conversion sequence, Gray coded along its path.
   typedef enum logic [1:0] {
      CV_IDLE  = 2'b00,
      CV_ARMED = 2'b01,
      CV_BUSY  = 2'b11,
      CV_SHIFT = 2'b10
   } tsc_conv_t;

   // Register select codes of the APB decoder.
   typedef enum logic [1:0] {
      RS_NONE   = 2'b00,
      RS_SAMPLE = 2'b01,
      RS_RESULT = 2'b11,
      RS_STATUS = 2'b10
   } tsc_rsel_t;

endpackage

// >>> tsc_serial_ctrl.sv
`timescale 1ns/1ns
module tsc_serial_ctrl #(
   parameter int RES_W = 12
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        select_n,
   input  wire logic        conv_clock,
   input  wire logic        serial_in,
   output logic             serial_out,
   output logic             serial_out_oe,
   output logic             busy,
   output logic             busy_oe,
   output logic      [2:0]  channel_sel,
   output logic             touch_drive,
   output logic             adc_power,
   output logic             ref_power,
   output logic             touch_irq_en
);

   // ----------------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------------
   // The bit counter is four bits wide and 8-bit mode needs a wider code.
   if (RES_W <= tsc_pkg::RES_LO || RES_W > 16) begin : g_bad_width
      $error("RES_W must lie above the short resolution and at most 16");
   end
   if (tsc_pkg::PIN_LATENCY_CYC > tsc_pkg::OUT_MAX_CYC) begin : g_bad_clock
      $error("Core clock too slow to answer conv_clock edges in time");
   end

   // ----------------------------------------------------------------------
   // Decoding
   // ----------------------------------------------------------------------
   // Maps a byte address onto a register select code.
   function automatic tsc_pkg::tsc_rsel_t reg_sel(input logic [7:0] addr);
      tsc_pkg::tsc_rsel_t sel;
      unique case (addr)
         tsc_pkg::OFF_SAMPLE: sel = tsc_pkg::RS_SAMPLE;
         tsc_pkg::OFF_RESULT: sel = tsc_pkg::RS_RESULT;
         tsc_pkg::OFF_STATUS: sel = tsc_pkg::RS_STATUS;
         default:             sel = tsc_pkg::RS_NONE;
      endcase
      return sel;
   endfunction

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   logic [2:0] pin_raw;
   logic [2:0] meta_reg;
   logic [2:0] sync_reg;
   logic       cclk_d_reg;

   assign pin_raw = {select_n, conv_clock, serial_in};

   // Each pin passes two flops; only the second stage is read by logic.
   for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            meta_reg[i] <= tsc_pkg::SYNC_RST[i];
            sync_reg[i] <= tsc_pkg::SYNC_RST[i];
         end else begin
            meta_reg[i] <= pin_raw[i];
            sync_reg[i] <= meta_reg[i];
         end
      end
   end

   // Delayed copy of the synchronised link clock for edge detection.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cclk_d_reg <= 1'b0;
      end else begin
         cclk_d_reg <= sync_reg[1];
      end
   end

   logic sel_act;
   logic cclk_rise;
   logic cclk_fall;
   logic sin;

   assign sel_act   = ~sync_reg[2];
   assign cclk_rise = sync_reg[1] & ~cclk_d_reg;
   assign cclk_fall = ~sync_reg[1] & cclk_d_reg;
   assign sin       = sync_reg[0];

   // ----------------------------------------------------------------------
   // Link state: control byte receiver and conversion sequencer
   // ----------------------------------------------------------------------
   logic [3:0]           rx_cnt_reg, rx_cnt_next;
   logic [6:0]           rx_shift_reg, rx_shift_next;
   tsc_pkg::tsc_ctrl_t   ctrl_reg, ctrl_next;
   tsc_pkg::tsc_conv_t   conv_reg, conv_next;
   logic [3:0]           bit_cnt_reg, bit_cnt_next;
   logic [RES_W-1:0]     data_reg, data_next;
   logic [RES_W-1:0]     result_reg, result_next;
   logic [RES_W-1:0]     sample_reg, sample_next;
   tsc_pkg::tsc_power_t  pwr_reg, pwr_next;
   logic                 sout_reg, sout_next;
   logic                 sout_oe_reg, sout_oe_next;
   logic                 busy_reg, busy_next;
   logic                 busy_oe_reg, busy_oe_next;
   logic                 acq_phase;
   logic                 conv_phase;

   // Next values of everything that faces the serial link.
   always_comb begin
      rx_cnt_next   = rx_cnt_reg;
      rx_shift_next = rx_shift_reg;
      ctrl_next     = ctrl_reg;
      conv_next     = conv_reg;
      bit_cnt_next  = bit_cnt_reg;
      data_next     = data_reg;
      result_next   = result_reg;
      sout_next     = sout_reg;
      busy_next     = busy_reg;
      pwr_next      = pwr_reg;
      sout_oe_next  = sel_act;
      busy_oe_next  = sel_act;
      if (!sel_act) begin
         rx_cnt_next = 4'h0;
         conv_next   = tsc_pkg::CV_IDLE;
         sout_next   = 1'b0;
         busy_next   = 1'b0;
      end else begin
         if (cclk_rise) begin
            if (rx_cnt_reg == 4'h0) begin
               if (sin) begin
                  rx_cnt_next   = 4'h1;
                  rx_shift_next = 7'h01;
               end
            end else if (rx_cnt_reg == 4'(tsc_pkg::CMD_BITS - 1)) begin
               ctrl_next   = tsc_pkg::tsc_ctrl_t'({rx_shift_reg, sin});
               rx_cnt_next = 4'h0;
               conv_next   = tsc_pkg::CV_ARMED;
            end else begin
               rx_shift_next = {rx_shift_reg[5:0], sin};
               rx_cnt_next   = rx_cnt_reg + 4'h1;
            end
         end
         if (cclk_fall) begin
            unique case (conv_reg)
               tsc_pkg::CV_ARMED: begin
                  busy_next    = 1'b1;
                  conv_next    = tsc_pkg::CV_BUSY;
                  sout_next    = 1'b0;
                  pwr_next.ref_on = ctrl_reg.power_bit1;
                  data_next    = sample_reg;
                  result_next  = ctrl_reg.res_8bit
                                 ? RES_W'(sample_reg[RES_W-1 -: tsc_pkg::RES_LO])
                                 : sample_reg;
               end
               tsc_pkg::CV_BUSY: begin
                  busy_next    = 1'b0;
                  sout_next    = data_reg[RES_W-1];
                  data_next    = {data_reg[RES_W-2:0], 1'b0};
                  bit_cnt_next = ctrl_reg.res_8bit ? 4'(tsc_pkg::RES_LO - 1)
                                                   : 4'(RES_W - 1);
                  conv_next    = tsc_pkg::CV_SHIFT;
               end
               tsc_pkg::CV_SHIFT: begin
                  if (bit_cnt_reg == 4'h0) begin
                     sout_next = 1'b0;
                     conv_next = tsc_pkg::CV_IDLE;
                  end else begin
                     sout_next    = data_reg[RES_W-1];
                     data_next    = {data_reg[RES_W-2:0], 1'b0};
                     bit_cnt_next = bit_cnt_reg - 4'h1;
                  end
               end
               tsc_pkg::CV_IDLE: begin
                  sout_next = 1'b0;
               end
            endcase
         end
      end
      acq_phase  = (rx_cnt_reg >= 4'(tsc_pkg::ACQ_AFTER_BITS))
                   || (conv_reg == tsc_pkg::CV_ARMED);
      conv_phase = (conv_reg == tsc_pkg::CV_BUSY) || (conv_reg == tsc_pkg::CV_SHIFT);
      pwr_next.drive  = sel_act && (acq_phase || (conv_phase && !ctrl_reg.ref_select));
      pwr_next.adc_on = sel_act && (ctrl_reg.power_bit0 || conv_reg != tsc_pkg::CV_IDLE);
      pwr_next.irq_en = !ctrl_reg.power_bit0 && (conv_reg == tsc_pkg::CV_IDLE);
   end

   // Registers of the link state; the reference bit is kept across deselect.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_cnt_reg   <= 4'h0;
         rx_shift_reg <= 7'h00;
         ctrl_reg     <= tsc_pkg::CTRL_RST;
         conv_reg     <= tsc_pkg::CV_IDLE;
         bit_cnt_reg  <= 4'h0;
         data_reg     <= '0;
         result_reg   <= '0;
         pwr_reg      <= '0;
         sout_reg     <= 1'b0;
         sout_oe_reg  <= 1'b0;
         busy_reg     <= 1'b0;
         busy_oe_reg  <= 1'b0;
      end else begin
         rx_cnt_reg   <= rx_cnt_next;
         rx_shift_reg <= rx_shift_next;
         ctrl_reg     <= ctrl_next;
         conv_reg     <= conv_next;
         bit_cnt_reg  <= bit_cnt_next;
         data_reg     <= data_next;
         result_reg   <= result_next;
         pwr_reg      <= pwr_next;
         sout_reg     <= sout_next;
         sout_oe_reg  <= sout_oe_next;
         busy_reg     <= busy_next;
         busy_oe_reg  <= busy_oe_next;
      end
   end

   // ----------------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------------
   logic                pready_reg, pready_next;
   logic                pslverr_reg, pslverr_next;
   logic [31:0]         prdata_reg, prdata_next;
   logic                apb_access;
   logic                apb_done;
   tsc_pkg::tsc_rsel_t  apb_sel;
   logic                apb_ok;
   logic [31:0]         status_word;

   // One wait state keeps read data and the error flag straight from flops.
   always_comb begin
      apb_access  = psel && penable;
      apb_done    = apb_access && pready_reg;
      apb_sel     = reg_sel(paddr);
      apb_ok      = (apb_sel != tsc_pkg::RS_NONE)
                    && (!pwrite || apb_sel == tsc_pkg::RS_SAMPLE);
      pready_next = apb_access && !pready_reg;
      sample_next = sample_reg;
      if (apb_done && pwrite && apb_sel == tsc_pkg::RS_SAMPLE) begin
         sample_next = pwdata[RES_W-1:0];
      end
      status_word = '0;
      status_word[tsc_pkg::ST_BUSY_BIT]  = busy_reg;
      status_word[tsc_pkg::ST_REF_BIT]   = pwr_reg.ref_on;
      status_word[tsc_pkg::ST_ADC_BIT]   = pwr_reg.adc_on;
      status_word[tsc_pkg::ST_DRIVE_BIT] = pwr_reg.drive;
      status_word[tsc_pkg::ST_IRQEN_BIT] = pwr_reg.irq_en;
      status_word[tsc_pkg::ST_STATE_LSB +: 2] = conv_reg;
      status_word[tsc_pkg::ST_CTRL_LSB +: 8]  = ctrl_reg;
      prdata_next = tsc_pkg::RDATA_RST;
      if (pready_next && !pwrite) begin
         unique case (apb_sel)
            tsc_pkg::RS_SAMPLE: prdata_next = 32'(sample_reg);
            tsc_pkg::RS_RESULT: prdata_next = 32'(result_reg);
            tsc_pkg::RS_STATUS: prdata_next = status_word;
            tsc_pkg::RS_NONE:   prdata_next = tsc_pkg::RDATA_RST;
         endcase
      end
      pslverr_next = pready_next && !apb_ok;
   end

   // Bus registers and the sample code that the converter will return.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= tsc_pkg::RDATA_RST;
         sample_reg  <= '0;
      end else begin
         pready_reg  <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg  <= prdata_next;
         sample_reg  <= sample_next;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign prdata        = prdata_reg;
   assign pready        = pready_reg;
   assign pslverr       = pslverr_reg;
   assign serial_out    = sout_reg;
   assign serial_out_oe = sout_oe_reg;
   assign busy          = busy_reg;
   assign busy_oe       = busy_oe_reg;
   assign channel_sel   = ctrl_reg.channel_sel;
   assign touch_drive   = pwr_reg.drive;
   assign adc_power     = pwr_reg.adc_on;
   assign ref_power     = pwr_reg.ref_on;
   assign touch_irq_en  = pwr_reg.irq_en;

endmodule

// >>> tsc_props.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// Port checks of the serial control block
// ----------------------------------------------------------------------------
module tsc_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic select_n,
   input wire logic conv_clock,
   input wire logic serial_out,
   input wire logic serial_out_oe,
   input wire logic busy,
   input wire logic busy_oe,
   input wire logic adc_power,
   input wire logic ref_power,
   input wire logic touch_irq_en,
   input wire logic touch_drive
);
   logic       cc_reg;
   logic       cc_next;
   logic [3:0] age_reg;
   logic [3:0] age_next;

   // Cycles since the last link clock fall; it saturates so a quiet link never wraps.
   always_comb begin
      cc_next  = conv_clock;
      age_next = (cc_reg && !conv_clock) ? 4'h0 : age_reg + {3'h0, age_reg != 4'hf};
   end

   // Registers of the edge age counter.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cc_reg  <= 1'b0;
         age_reg <= 4'hf;
      end else begin
         cc_reg  <= cc_next;
         age_reg <= age_next;
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Release after deselect, and the busy pulse of one link clock period.
   sequence s_released;
      ##[1:5] (!serial_out_oe && !busy_oe && !busy);
   endsequence
   sequence s_busy_pulse;
      busy [*6] ##[1:4] !busy;
   endsequence

   property p_out_edge;
      $changed(serial_out) && serial_out_oe && !select_n |-> age_reg <= 4'h6;
   endproperty
   a_out_edge: assert property (p_out_edge)
      else $error("serial_out changed away from a link clock fall");
   property p_busy_edge;
      $rose(busy) |-> age_reg <= 4'h6;
   endproperty
   a_busy_edge: assert property (p_busy_edge)
      else $error("busy rose away from a link clock fall");
   property p_busy_len;
      $rose(busy) |-> s_busy_pulse;
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("busy pulse has the wrong length");
   property p_release;
      $rose(select_n) |-> s_released;
   endproperty
   a_release: assert property (p_release)
      else $error("outputs not released after deselect");
   property p_enable;
      $fell(select_n) ##0 (!select_n) [*6] |-> serial_out_oe && busy_oe;
   endproperty
   a_enable: assert property (p_enable)
      else $error("outputs not driven after select");
   property p_idle_off;
      select_n [*6] |-> !serial_out_oe && !busy_oe;
   endproperty
   a_idle_off: assert property (p_idle_off)
      else $error("outputs driven while deselected");
   property p_ref_hold;
      $changed(ref_power) |-> busy;
   endproperty
   a_ref_hold: assert property (p_ref_hold)
      else $error("reference power changed outside busy");
   property p_irq_busy;
      busy |-> !touch_irq_en;
   endproperty
   a_irq_busy: assert property (p_irq_busy)
      else $error("pen interrupt enabled during conversion");
   property p_irq_pwr;
      touch_irq_en |-> !adc_power;
   endproperty
   a_irq_pwr: assert property (p_irq_pwr)
      else $error("converter powered while pen interrupt enabled");
   // Drivers are still on in the cycle that ends acquisition, in both reference modes.
   property p_drive_acq;
      $rose(busy) |-> touch_drive;
   endproperty
   a_drive_acq: assert property (p_drive_acq)
      else $error("touch drivers off at the end of acquisition");
endmodule

// >>> tsc_host.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// Serial master model of the host
// ----------------------------------------------------------------------------
module tsc_host (
   output logic      select_n,
   output logic      conv_clock,
   output logic      serial_in,
   input  wire logic serial_out,
   input  wire logic serial_out_oe
);
   // The link clock rests low between frames.
   initial begin
      select_n   = 1'b1;
      conv_clock = 1'b0;
      serial_in  = 1'b1;
   end

   // Clock k presents din[64-k] and captures dout[64-k]; an undriven line reads unknown.
   task automatic run(input logic [63:0] din, input int n, output logic [63:0] dout);
      dout = 64'h0;
      #39 select_n = 1'b0;
      #160;
      for (int k = 1; k <= n; k++) begin
         serial_in = din[64-k];
         #160 conv_clock = 1'b1;
         dout[64-k] = serial_out_oe ? serial_out : 1'bx;
         #160 conv_clock = 1'b0;
      end
      #160 select_n = 1'b1;
      // The released data line shows the inverse, so no stale value looks valid.
      serial_in = ~serial_in;
   endtask
endmodule

// >>> touch_adc_serial_control_test.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// Self-checking bench of the serial control block
// ----------------------------------------------------------------------------
module touch_adc_serial_control_test;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic [2:0]  channel_sel;
   logic        pready, pslverr, select_n, conv_clock, serial_in, serial_out;
   logic        serial_out_oe, busy, busy_oe, touch_drive, adc_power, ref_power;
   logic        touch_irq_en;
   logic [31:0] seed = 32'h0000_bc92;
   int          failures = 0;
   int          num_checks = 0;

   // Core clock.
   always #20 pclk = ~pclk;

   tsc_serial_ctrl u_tsc_serial_ctrl (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .select_n, .conv_clock, .serial_in, .serial_out, .serial_out_oe, .busy,
      .busy_oe, .channel_sel, .touch_drive, .adc_power, .ref_power, .touch_irq_en
   );
   tsc_host u_tsc_host (.select_n, .conv_clock, .serial_in, .serial_out, .serial_out_oe);

   // Xorshift keeps the random stimulus repeatable.
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Code expected for a stored sample; low resolution keeps the top eight bits.
   function automatic logic [11:0] exp_code(input logic [11:0] s, input logic low);
      return low ? {4'h0, s[11:4]} : s;
   endfunction

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // One APB transfer; the request is held until pready is seen high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) failures++;
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // One frame with z idle clocks before the start bit; drivers are sampled mid-shift.
   task automatic conv(input logic [7:0] c, input logic [11:0] s, input int z);
      logic [63:0] d;
      logic [31:0] rd;
      logic [11:0] got;
      logic        er, drv, adc, adc_cv;
      fork
         u_tsc_host.run({56'h0, c} << (56 - z), 24 + z, d);
         begin
            @(posedge busy);
            repeat (12) @(posedge pclk);
            drv = touch_drive;
            adc_cv = adc_power;
            // Idle but still selected: the result has ended and select_n is low.
            repeat (100) @(posedge pclk);
            adc = adc_power;
         end
      join
      got = c[3] ? {4'h0, d[54-z -: 8]} : d[54-z -: 12];
      repeat (8) @(posedge pclk);
      chk("link code", 32'(exp_code(s, c[3])), 32'(got));
      chk("frame end", 32'h0, 32'(d[(c[3] ? 46 : 42) - z]));
      chk("drivers", 32'(!c[2]), 32'(drv));
      chk("channel", 32'(c[6:4]), 32'(channel_sel));
      chk("reference", 32'(c[1]), 32'(ref_power));
      chk("converter busy", 32'h1, 32'(adc_cv));
      chk("converter idle", 32'(c[0]), 32'(adc));
      chk("converter off", 32'h0, 32'(adc_power));
      chk("pen irq", 32'(!c[0]), 32'(touch_irq_en));
      apb(1'b0, tsc_pkg::OFF_RESULT, 32'h0, rd, er);
      chk("result reg", 32'(exp_code(s, c[3])), rd);
   endtask

   // Main sequence: registers, every mode code, abort, then overlapped frames.
   initial begin
      logic [63:0] d;
      logic [31:0] rd, s;
      logic [7:0]  c;
      logic        er;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b1, tsc_pkg::OFF_SAMPLE, 32'hffff_fabc, rd, er);
      apb(1'b0, tsc_pkg::OFF_SAMPLE, 32'h0000_0000, rd, er);
      chk("sample readback", 32'h0000_0abc, rd);
      apb(1'b0, 8'h0c, 32'h0000_0000, rd, er);
      chk("unmapped error", 32'h1, 32'(er));
      chk("unmapped data", 32'h0, rd);
      apb(1'b1, tsc_pkg::OFF_RESULT, 32'h0000_0055, rd, er);
      chk("read-only error", 32'h1, 32'(er));
      for (int i = 0; i < 16; i++) begin
         c = {1'b1, 3'(rnd()), 4'(i)};
         s = (i == 0) ? 32'h0 : (i == 15) ? 32'h0000_0fff : rnd() & 32'h0000_0fff;
         apb(1'b1, tsc_pkg::OFF_SAMPLE, s, rd, er);
         conv(c, s[11:0], i % 3);
      end
      // Deselect in mid-conversion with the reference requested on.
      u_tsc_host.run(64'h9600_0000_0000_0000, 12, d);
      repeat (8) @(posedge pclk);
      chk("busy abort", 32'h0, 32'(busy));
      chk("adc abort", 32'h0, 32'(adc_power));
      chk("ref kept", 32'h1, 32'(ref_power));
      apb(1'b0, tsc_pkg::OFF_STATUS, 32'h0, rd, er);
      chk("state abort", 32'h0, 32'(rd[tsc_pkg::ST_STATE_LSB +: 2]));
      chk("status ref", 32'h1, 32'(rd[tsc_pkg::ST_REF_BIT]));
      // Mid-run reset clears the latched reference and the stored sample.
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("reset ref", 32'h0, 32'(ref_power));
      presetn <= 1'b1;
      apb(1'b0, tsc_pkg::OFF_SAMPLE, 32'h0, rd, er);
      chk("reset sample", 32'h0, rd);
      s = rnd() & 32'h0000_0fff;
      apb(1'b1, tsc_pkg::OFF_SAMPLE, s, rd, er);
      // Second byte starts on clock 16 while the first result shifts out.
      u_tsc_host.run({8'h83, 7'h0, 8'h90, 41'h0}, 37, d);
      repeat (8) @(posedge pclk);
      chk("overlap first", s, 32'(d[54:43]));
      chk("overlap second", s, 32'(d[39:28]));
      chk("ref off", 32'h0, 32'(ref_power));
      chk("overlap channel", 32'h1, 32'(channel_sel));
      stop_test();
   end

   // Watchdog well beyond the expected run of about 165 us.
   initial begin
      #2000000;
      failures++;
      stop_test();
   end
endmodule

// Port checks attached to the design.
bind tsc_serial_ctrl tsc_props u_tsc_props (
   .pclk, .presetn, .select_n, .conv_clock, .serial_out, .serial_out_oe, .busy,
   .busy_oe, .adc_power, .ref_power, .touch_irq_en, .touch_drive
);
